// *** hw/sbg_pkg.sv ***
package sbg_pkg;
    localparam int SBG_NINIT = 14;
    localparam int SBG_NTGT = 14;
    localparam int SBG_NRGN = 9;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] SBG_CFG_OFS = 12'h000;
    localparam logic [11:0] SBG_UNLOCK_OFS = 12'h004;
    localparam logic [11:0] SBG_GROUP_OFS = 12'h008;
    localparam logic [1:0] SBG_PERM_BASE = 2'h1;
    localparam int SBG_DMA_PRI_BIT = 25;
    localparam int SBG_CPU_PRI_BIT = 24;
    localparam int SBG_LOCK_BIT = 11;
    localparam logic [31:0] SBG_CFG_RESET = 32'h0000_0000;
    localparam logic [27:0] SBG_GROUP_RESET = 28'h000_0000;
    localparam logic [3:0] SBG_PERM_RESET = 4'h7;
    // Unlock keys, values arbitrary
    localparam logic [31:0] SBG_KEY1 = 32'h0000_C0DE;
    localparam logic [31:0] SBG_KEY2 = 32'h0000_F00D;
    // ------------------------------------------------------------
    // Initiators and targets
    // ------------------------------------------------------------
    localparam logic [13:0] SBG_HIGH_CAPABLE = 14'h102A;
    localparam int SBG_CPU_IDX = 1;
    localparam int SBG_DMA_IDX = 3;
    localparam logic [3:0] SBG_SRAM_TGT = 4'h1;
    // Read-only permission bits of target 0
    localparam logic [3:0] SBG_T0_RO_MASK = 4'h1;
    typedef enum logic [2:0] {
        SBG_UL_IDLE = 3'b001,
        SBG_UL_KEY1 = 3'b010,
        SBG_UL_OPEN = 3'b100
    } sbg_unlock_t;
endpackage : sbg_pkg

// *** hw/sbg_guard.sv ***
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/100ps
module sbg_guard (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Initiator requests
    input wire logic [sbg_pkg::SBG_NINIT-1:0] REQ,
    input wire logic [sbg_pkg::SBG_NINIT-1:0] REQ_WR,
    input wire logic [4*sbg_pkg::SBG_NINIT-1:0] REQ_TGT,
    input wire logic [4*sbg_pkg::SBG_NINIT-1:0] REQ_RGN,
    input wire logic CPU_EXL,
    // Grant
    output logic [sbg_pkg::SBG_NINIT-1:0] GNT,
    output logic GNT_HIGH,
    output logic GNT_WR_BLOCK
);
    import sbg_pkg::*;

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic [31:0] cfg_q, cfg_d;
    logic [27:0] group_q, group_d;
    logic [3:0] perm_q [SBG_NTGT][SBG_NRGN];
    logic [3:0] perm_d [SBG_NTGT][SBG_NRGN];
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    sbg_unlock_t ul_q, ul_d;
    logic acc, wr_done;
    logic is_cfg, is_ul, is_grp, is_perm, mapped;
    logic [3:0] a_tgt, a_rgn;
    logic locked;

    assign acc = PSEL && PENABLE;
    assign wr_done = acc && pready_q && PWRITE;
    assign a_tgt = PADDR[9:6];
    assign a_rgn = PADDR[5:2];
    assign is_cfg = PADDR == SBG_CFG_OFS;
    assign is_ul = PADDR == SBG_UNLOCK_OFS;
    assign is_grp = PADDR == SBG_GROUP_OFS;
    assign is_perm = PADDR[11:10] == SBG_PERM_BASE && PADDR[1:0] == 2'h0
        && a_tgt < 4'(SBG_NTGT) && a_rgn < 4'(SBG_NRGN);
    assign mapped = is_cfg || is_ul || is_grp || is_perm;
    assign locked = cfg_q[SBG_LOCK_BIT];

    always_comb begin
        pready_d = acc && !pready_q;
        pslverr_d = acc && !pready_q && !mapped;
        prdata_d = prdata_q;
        if (acc && !pready_q && !PWRITE) begin
            prdata_d = 32'h0000_0000;
            if (is_cfg) begin
                prdata_d = cfg_q;
            end else if (is_grp) begin
                prdata_d = {4'h0, group_q};
            end else if (is_perm) begin
                prdata_d = {28'h000_0000, perm_q[a_tgt][a_rgn]};
            end
        end
    end

    // Unlock sequencer: two keys, then one lock-bit change
    always_comb begin
        ul_d = ul_q;
        if (wr_done) begin
            case (ul_q)
                SBG_UL_IDLE: begin
                    if (is_ul && PWDATA == SBG_KEY1) begin
                        ul_d = SBG_UL_KEY1;
                    end
                end
                SBG_UL_KEY1: begin
                    if (is_ul && PWDATA == SBG_KEY2) begin
                        ul_d = SBG_UL_OPEN;
                    end else begin
                        ul_d = SBG_UL_IDLE;
                    end
                end
                SBG_UL_OPEN: begin
                    // Any write closes the window again
                    ul_d = SBG_UL_IDLE;
                end
                default: begin
                    ul_d = SBG_UL_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        cfg_d = cfg_q;
        group_d = group_q;
        perm_d = perm_q;
        if (wr_done && is_cfg) begin
            cfg_d = PWDATA;
            if (ul_q != SBG_UL_OPEN) begin
                cfg_d[SBG_LOCK_BIT] = locked;
            end
        end
        if (wr_done && is_grp && !locked) begin
            group_d = PWDATA[27:0];
        end
        if (wr_done && is_perm && !locked) begin
            perm_d[a_tgt][a_rgn] = PWDATA[3:0];
            if (a_tgt == 4'h0) begin
                perm_d[a_tgt][a_rgn] = (PWDATA[3:0] & ~SBG_T0_RO_MASK)
                    | (perm_q[a_tgt][a_rgn] & SBG_T0_RO_MASK);
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cfg_q <= SBG_CFG_RESET;
            group_q <= SBG_GROUP_RESET;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            ul_q <= SBG_UL_IDLE;
            for (int t = 0; t < SBG_NTGT; t++) begin
                for (int r = 0; r < SBG_NRGN; r++) begin
                    perm_q[t][r] <= SBG_PERM_RESET;
                end
            end
        end else begin
            cfg_q <= cfg_d;
            group_q <= group_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            ul_q <= ul_d;
            perm_q <= perm_d;
        end
    end

    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;

    // ------------------------------------------------------------
    // Arbiter
    // ------------------------------------------------------------
    // older_q[i][j] set: i was served less recently than j
    logic [SBG_NINIT-1:0] older_q [SBG_NINIT];
    logic [SBG_NINIT-1:0] older_d [SBG_NINIT];
    logic [SBG_NINIT-1:0] high, cand, win;
    logic [SBG_NINIT-1:0] gnt_q, gnt_d;
    logic gnt_high_q, gnt_high_d;
    logic blk_q, blk_d;
    logic [3:0] w_tgt, w_rgn;
    logic [1:0] w_grp;

    always_comb begin
        high = '0;
        high[SBG_DMA_IDX] = cfg_q[SBG_DMA_PRI_BIT]
            && REQ_TGT[4*SBG_DMA_IDX +: 4] == SBG_SRAM_TGT;
        high[SBG_CPU_IDX] = cfg_q[SBG_CPU_PRI_BIT] && CPU_EXL
            && REQ_TGT[4*SBG_CPU_IDX +: 4] == SBG_SRAM_TGT;
        high = high & SBG_HIGH_CAPABLE & REQ;
        cand = (|high) ? high : REQ;
        win = '0;
        for (int i = 0; i < SBG_NINIT; i++) begin
            win[i] = cand[i];
            for (int j = 0; j < SBG_NINIT; j++) begin
                if (j != i && cand[j] && !older_q[i][j]) begin
                    win[i] = 1'b0;
                end
            end
        end
    end

    always_comb begin
        older_d = older_q;
        w_tgt = 4'h0;
        w_rgn = 4'h0;
        w_grp = 2'h0;
        for (int g = 0; g < SBG_NINIT; g++) begin
            if (win[g]) begin
                w_tgt = REQ_TGT[4*g +: 4];
                w_rgn = REQ_RGN[4*g +: 4];
                w_grp = group_q[2*g +: 2];
                for (int j = 0; j < SBG_NINIT; j++) begin
                    if (j != g) begin
                        older_d[g][j] = 1'b0;
                        older_d[j][g] = 1'b1;
                    end
                end
            end
        end
        gnt_d = win;
        gnt_high_d = |(win & high);
        // Out-of-range target or region is never writable
        blk_d = |(win & REQ_WR);
        if (w_tgt < 4'(SBG_NTGT) && w_rgn < 4'(SBG_NRGN)) begin
            blk_d = |(win & REQ_WR) && !perm_q[w_tgt][w_rgn][w_grp];
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            gnt_q <= '0;
            gnt_high_q <= 1'b0;
            blk_q <= 1'b0;
            for (int i = 0; i < SBG_NINIT; i++) begin
                for (int j = 0; j < SBG_NINIT; j++) begin
                    older_q[i][j] <= i < j;
                end
            end
        end else begin
            gnt_q <= gnt_d;
            gnt_high_q <= gnt_high_d;
            blk_q <= blk_d;
            older_q <= older_d;
        end
    end

    assign GNT = gnt_q;
    assign GNT_HIGH = gnt_high_q;
    assign GNT_WR_BLOCK = blk_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_grant_onehot: assert property (@(posedge CLK) disable iff (RST)
        $onehot0(GNT) && (GNT == '0 || |(GNT & $past(REQ))))
        else $error("grant not one-hot or not requested");
    chk_lrs_order: assert property (@(posedge CLK) disable iff (RST)
        GNT[0] && REQ[0] && REQ[2] && high == '0 |=> !GNT[0])
        else $error("served initiator won again over waiting one");
    chk_high_wins: assert property (@(posedge CLK) disable iff (RST)
        |high |=> |(GNT & $past(high)) && GNT_HIGH)
        else $error("high priority request lost");
    chk_high_capable: assert property (@(posedge CLK) disable iff (RST)
        (high & ~SBG_HIGH_CAPABLE) == '0)
        else $error("incapable initiator in high priority");
    chk_cpu_exl: assert property (@(posedge CLK) disable iff (RST)
        !CPU_EXL |-> !high[SBG_CPU_IDX])
        else $error("cpu high priority outside exception");
    chk_dma_bit: assert property (@(posedge CLK) disable iff (RST)
        high[SBG_DMA_IDX] |-> cfg_q[SBG_DMA_PRI_BIT]
        && REQ_TGT[4*SBG_DMA_IDX +: 4] == SBG_SRAM_TGT)
        else $error("dma high priority without select");
    chk_lock_holds: assert property (@(posedge CLK) disable iff (RST)
        ul_q != SBG_UL_OPEN |=> cfg_q[SBG_LOCK_BIT]
        == $past(cfg_q[SBG_LOCK_BIT]))
        else $error("lock bit changed without unlock");
    chk_locked_grp: assert property (@(posedge CLK) disable iff (RST)
        locked |=> group_q == $past(group_q))
        else $error("group register written while locked");
    chk_perm_write: assert property (@(posedge CLK) disable iff (RST)
        wr_done && is_perm && !locked && a_tgt != 4'h0
        |=> perm_q[$past(a_tgt)][$past(a_rgn)] == $past(PWDATA[3:0]))
        else $error("permission write lost");
    chk_ro_bits: assert property (@(posedge CLK) disable iff (RST)
        wr_done && is_perm && a_tgt == 4'h0 |=> (perm_q[0][$past(a_rgn)]
        & SBG_T0_RO_MASK) == ($past(perm_q[0][a_rgn]) & SBG_T0_RO_MASK))
        else $error("read-only permission bit changed");
    chk_read_zero: assert property (@(posedge CLK) disable iff (RST)
        pready_d && !PWRITE && is_perm |=> PRDATA[31:4] == 28'h000_0000)
        else $error("unimplemented bits read nonzero");
    chk_block: assert property (@(posedge CLK) disable iff (RST)
        |(win & REQ_WR) && w_tgt < 4'(SBG_NTGT) && w_rgn < 4'(SBG_NRGN)
        && !perm_q[w_tgt][w_rgn][w_grp] |=> GNT_WR_BLOCK)
        else $error("unpermitted write not blocked");

    // ------------------------------------------------------------
    // Arbiter checks
    // ------------------------------------------------------------
    // The winner vector must never name two initiators at once
    chk_win_onehot: assert property (@(posedge CLK) disable iff (RST)
        $onehot0(win))
        else $error("more than one arbitration winner");
    chk_idle_no_gnt: assert property (@(posedge CLK) disable iff (RST)
        REQ == '0 |=> GNT == '0)
        else $error("grant issued without any request");
    chk_high_only: assert property (@(posedge CLK) disable iff (RST)
        |high |=> (GNT & ~$past(high)) == '0)
        else $error("low priority won over high priority");
    chk_high_flag_src: assert property (@(posedge CLK) disable iff (RST)
        GNT_HIGH |-> |(GNT & SBG_HIGH_CAPABLE))
        else $error("high flag on incapable initiator");
    chk_dma_low: assert property (@(posedge CLK) disable iff (RST)
        !cfg_q[SBG_DMA_PRI_BIT] |-> !high[SBG_DMA_IDX])
        else $error("dma high priority while deselected");
    chk_cpu_bit: assert property (@(posedge CLK) disable iff (RST)
        high[SBG_CPU_IDX] |-> cfg_q[SBG_CPU_PRI_BIT]
        && REQ_TGT[4*SBG_CPU_IDX +: 4] == SBG_SRAM_TGT)
        else $error("cpu high priority without select");
    // Reads never raise the block flag
    chk_read_free: assert property (@(posedge CLK) disable iff (RST)
        !(|(win & REQ_WR)) |=> !GNT_WR_BLOCK)
        else $error("block flag without a granted write");
    chk_block_free: assert property (@(posedge CLK) disable iff (RST)
        |(win & REQ_WR) && w_tgt < 4'(SBG_NTGT) && w_rgn < 4'(SBG_NRGN)
        && perm_q[w_tgt][w_rgn][w_grp] |=> !GNT_WR_BLOCK)
        else $error("permitted write was blocked");

    // ------------------------------------------------------------
    // Register checks
    // ------------------------------------------------------------
    // PREADY is a single-cycle answer, never a level
    chk_ready_pulse: assert property (@(posedge CLK) disable iff (RST)
        PREADY |=> !PREADY)
        else $error("ready held for more than one cycle");
    chk_locked_perm: assert property (@(posedge CLK) disable iff (RST)
        wr_done && is_perm && locked
        |=> perm_q[$past(a_tgt)][$past(a_rgn)]
        == $past(perm_q[a_tgt][a_rgn]))
        else $error("permission written while locked");
    chk_grp_write: assert property (@(posedge CLK) disable iff (RST)
        wr_done && is_grp && !locked |=> group_q == $past(PWDATA[27:0]))
        else $error("group assignment write lost");
    chk_lock_opens: assert property (@(posedge CLK) disable iff (RST)
        wr_done && is_cfg && ul_q == SBG_UL_OPEN
        |=> cfg_q[SBG_LOCK_BIT] == $past(PWDATA[SBG_LOCK_BIT]))
        else $error("lock bit not taken in unlock window");
    chk_perm_read: assert property (@(posedge CLK) disable iff (RST)
        pready_d && !PWRITE && is_perm
        |=> PRDATA[3:0] == $past(perm_q[a_tgt][a_rgn]))
        else $error("permission read returned wrong value");
    chk_err_unmapped: assert property (@(posedge CLK) disable iff (RST)
        acc && !pready_q && !mapped |=> PSLVERR && PREADY)
        else $error("unmapped access without error");
endmodule : sbg_guard

// *** sim/sbg_init_model.sv ***
`timescale 1ns/100ps
module sbg_init_model (
    // Clock
    input wire logic CLK,
    // Requests toward the guard
    output logic [13:0] REQ,
    output logic [13:0] REQ_WR,
    output logic [55:0] REQ_TGT,
    output logic [55:0] REQ_RGN,
    output logic CPU_EXL
);
    initial begin
        REQ = 14'h0000;
        REQ_WR = 14'h0000;
        REQ_TGT = 56'h0;
        REQ_RGN = 56'h0;
        CPU_EXL = 1'b0;
    end

    task automatic drive(input logic [13:0] r, input logic [13:0] w,
                         input logic [3:0] t, input logic [3:0] g,
                         input logic x);
        @(posedge CLK);
        REQ <= r;
        REQ_WR <= w;
        // Idle fields toggle, so a stale target is never mistaken as live
        REQ_TGT <= (r != 14'h0000) ? {14{t}} : {14{~t}};
        REQ_RGN <= (r != 14'h0000) ? {14{g}} : {14{~g}};
        CPU_EXL <= x;
    endtask : drive
endmodule : sbg_init_model

// *** sim/sbg_guard_tb_top.sv ***
`timescale 1ns/100ps
module sbg_guard_tb_top;
    import sbg_pkg::*;
    logic CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, er;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    logic [13:0] REQ, REQ_WR, GNT;
    logic [55:0] REQ_TGT, REQ_RGN;
    logic CPU_EXL, GNT_HIGH, GNT_WR_BLOCK;
    int error_cnt = 0;
    int n_checks = 0;

    sbg_guard dut_u (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .REQ(REQ), .REQ_WR(REQ_WR),
        .REQ_TGT(REQ_TGT), .REQ_RGN(REQ_RGN), .CPU_EXL(CPU_EXL), .GNT(GNT),
        .GNT_HIGH(GNT_HIGH), .GNT_WR_BLOCK(GNT_WR_BLOCK));
    sbg_init_model init_u (.CLK(CLK), .REQ(REQ), .REQ_WR(REQ_WR),
        .REQ_TGT(REQ_TGT), .REQ_RGN(REQ_RGN), .CPU_EXL(CPU_EXL));

    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end

    task automatic tally_and_finish();
        if (error_cnt == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    // ------------------------------------------------------------
    // APB master
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 50);
        if (n >= 50)
            chk("pready", 32'h1, {31'h0, PREADY});
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdchk(input string nm, input logic [11:0] a,
                         input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask : rdchk

    // Grant lands one edge after the request set is driven
    task automatic gnt(input logic [13:0] g, input logic h, input logic b);
        @(posedge CLK);
        #1;
        chk("gnt", {18'h0, g}, {18'h0, GNT});
        chk("gnt_high", {31'h0, h}, {31'h0, GNT_HIGH});
        chk("wr_block", {31'h0, b}, {31'h0, GNT_WR_BLOCK});
    endtask : gnt

    initial begin
        repeat (5000) @(posedge CLK);
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        RST = 1'b1;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 12'h000;
        PWDATA = 32'h0;
        repeat (12) @(posedge CLK);
        RST <= 1'b0;
        init_u.drive(14'h0005, 14'h0000, 4'h1, 4'h0, 1'b0);
        gnt(14'h0001, 1'b0, 1'b0);
        gnt(14'h0004, 1'b0, 1'b0);
        gnt(14'h0001, 1'b0, 1'b0);
        wr(SBG_CFG_OFS, 32'h0300_0000);
        init_u.drive(14'h0009, 14'h0000, SBG_SRAM_TGT, 4'h0, 1'b0);
        gnt(14'h0008, 1'b1, 1'b0);
        gnt(14'h0008, 1'b1, 1'b0);
        init_u.drive(14'h0008, 14'h0000, 4'h2, 4'h0, 1'b0);
        gnt(14'h0008, 1'b0, 1'b0);
        init_u.drive(14'h0002, 14'h0000, SBG_SRAM_TGT, 4'h0, 1'b0);
        gnt(14'h0002, 1'b0, 1'b0);
        init_u.drive(14'h0003, 14'h0000, SBG_SRAM_TGT, 4'h0, 1'b1);
        gnt(14'h0002, 1'b1, 1'b0);
        gnt(14'h0002, 1'b1, 1'b0);
        init_u.drive(14'h0020, 14'h0000, SBG_SRAM_TGT, 4'h0, 1'b1);
        gnt(14'h0020, 1'b0, 1'b0);
        for (int g = 0; g < 4; g++) begin
            wr(SBG_GROUP_OFS, 32'(g));
            wr(12'h480, 32'h1 << g);
            init_u.drive(14'h0001, 14'h0001, 4'h2, 4'h0, 1'b0);
            gnt(14'h0001, 1'b0, 1'b0);
            wr(12'h480, 32'hF ^ (32'h1 << g));
            gnt(14'h0001, 1'b0, 1'b1);
        end
        rdchk("perm_reset", 12'h4C0, 32'h7);
        rdchk("perm_last", 12'h760, 32'h7);
        wr(12'h4C4, 32'hFFFF_FFFF);
        rdchk("perm_upper", 12'h4C4, 32'hF);
        wr(12'h404, 32'h0);
        rdchk("perm_preset", 12'h404, 32'h1);
        rdchk("unmapped", 12'h0C0, 32'h0);
        chk("slverr", 32'h1, {31'h0, er});
        wr(SBG_CFG_OFS, 32'h800);
        rdchk("lock_nokey", SBG_CFG_OFS, 32'h0);
        wr(SBG_UNLOCK_OFS, SBG_KEY1);
        wr(SBG_UNLOCK_OFS, SBG_KEY2);
        wr(SBG_CFG_OFS, 32'h800);
        rdchk("lock_set", SBG_CFG_OFS, 32'h800);
        wr(12'h4C0, 32'h2);
        rdchk("perm_locked", 12'h4C0, 32'h7);
        wr(SBG_CFG_OFS, 32'h0);
        rdchk("lock_kept", SBG_CFG_OFS, 32'h800);
        tally_and_finish();
    end
endmodule : sbg_guard_tb_top
